/* ssr_pkg.sv */
// constants shared by the shared-store region logic
package ssr_pkg;
    localparam int NPIX       = 16;  // 4 by 4 pixels
    localparam int NTMR       = 16;  // latency timers per region
    localparam int NSTG       = 4;   // staging entries
    localparam int NSLOT      = 8;   // pulse-width slots per timer
    localparam int TOTW       = 4;
    localparam int LATW       = 9;
    localparam int SETW       = 6;
    localparam int TIDW       = 5;
    localparam int PKTW       = TIDW + NPIX * TOTW;
    localparam int FIFO_DEPTH = 16;
    localparam logic [TOTW-1:0] TOT_RST     = 4'h0;
    localparam logic [TOTW-1:0] TOT_FIRST   = 4'h1;
    localparam logic [TOTW-1:0] TOT_MAX     = 4'hf;
    localparam logic [TOTW-1:0] TOT_SAT_MIN = 4'he;
    localparam logic [TOTW-1:0] TOT_SAT     = 4'hf;
    localparam logic [TOTW-1:0] TOT_LOST    = 4'he;
    localparam logic [LATW-1:0] AGE_RST     = 9'h000;
    localparam logic [SETW-1:0] CNT_RST     = 6'h00;
    localparam logic [SETW-1:0] CNT_MAX     = 6'h3f;
endpackage : ssr_pkg

/* ssr_region.sv */
// shared-store region: pixel counters, staging, timers, adapter, fifo
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
// fifo with a registered output stage
module ssr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    input  wire logic             out_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             load;

    // full stalls the adapter upstream
    assign in_ready = (count_r != FULL);
    assign push     = in_valid & in_ready;
    assign load     = (count_r != '0) & (~out_valid | out_ready);

    // storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (load) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !load) begin
                count_r <= count_r + 1'b1;
            end else if (!push && load) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // output register so the top sees flip-flop outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : ssr_fifo

////////////////////////////////////////////////////////////////////////
module ssr_region (
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire logic [ssr_pkg::NPIX-1:0]  disc,
    input  wire logic [ssr_pkg::LATW-1:0]  latency,
    input  wire logic [ssr_pkg::SETW-1:0]  settle_time,
    input  wire logic                      trigger,
    input  wire logic [ssr_pkg::TIDW-1:0]  trigger_id,
    input  wire logic                      out_ready,
    output logic                           out_valid,
    output logic      [ssr_pkg::PKTW-1:0]  out_data,
    output logic                           hit_lost
);
    import ssr_pkg::*;

    // returns {found, index} of the lowest clear bit
    function automatic logic [4:0] first_clear(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (!v[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : first_clear

    logic [NPIX-1:0] disc_d_r;
    logic [NPIX-1:0] hit_edge;
    logic [TOTW-1:0] tot_r [NPIX];
    logic [NTMR-1:0] tmr_busy_r;
    logic [NTMR-1:0] tmr_trig_r;
    logic [LATW-1:0] tmr_age_r [NTMR];
    logic [NPIX-1:0] tmr_map_r [NTMR];
    logic [TOTW-1:0] tmr_tot_r [NTMR][NSLOT];
    logic [TIDW-1:0] tmr_tid_r [NTMR];
    logic [NSTG-1:0] stg_busy_r;
    logic [NPIX-1:0] stg_map_r [NSTG];
    logic [SETW-1:0] stg_cnt_r [NSTG];
    logic [3:0]      stg_tmr_r [NSTG];
    logic [NSTG-1:0] stg_done;
    logic [4:0]      tmr_free;
    logic [4:0]      stg_free;
    logic [4:0]      zs_pick;
    logic [4:0]      rd_pick;
    logic            region_start;
    logic            start;
    logic            zs_fire;
    logic [3:0]      zs_tmr;
    logic [NPIX-1:0] zs_map;
    logic [TOTW-1:0] zs_tot [NSLOT];
    logic [NPIX-1:0] pkt_map;
    logic [TOTW-1:0] pkt_tot [NSLOT];
    logic [PKTW-1:0] pkt_data;
    logic            pkt_push;
    logic            fifo_in_ready;

    ////////////////////////////////////////////////////////////////////
    // pixel front: hit present and pulse-width counters
    assign hit_edge = disc & ~disc_d_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            disc_d_r <= '0;
        end else begin
            disc_d_r <= disc;
        end
    end

    for (genvar p = 0; p < NPIX; p++) begin : g_pix
        // a new pulse restarts the count of that pixel
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                tot_r[p] <= TOT_RST;
            end else if (hit_edge[p]) begin
                tot_r[p] <= TOT_FIRST;
            end else if (disc[p] && tot_r[p] != TOT_MAX) begin
                tot_r[p] <= tot_r[p] + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // allocation: one timer and one staging slot per crossing
    always_comb begin
        tmr_free     = first_clear(tmr_busy_r);
        stg_free     = first_clear({12'hfff, stg_busy_r});
        region_start = |hit_edge;
        start        = region_start & tmr_free[4] & stg_free[4];
    end

    // a hit with no staging room or no free timer is lost
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hit_lost <= 1'b0;
        end else begin
            hit_lost <= region_start & ~start;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // zero suppression of the lowest-numbered settled staging entry
    always_comb begin
        logic [4:0] k;
        k = 5'h00;
        for (int s = 0; s < NSTG; s++) begin
            // >= so a late twin still finishes a cycle later
            stg_done[s] = stg_busy_r[s] &&
                          (stg_cnt_r[s] >= settle_time);
        end
        zs_pick = first_clear(~{12'h000, stg_done});
        zs_fire = zs_pick[4];
        zs_map  = stg_map_r[zs_pick[1:0]];
        zs_tmr  = stg_tmr_r[zs_pick[1:0]];
        for (int i = 0; i < NSLOT; i++) begin
            zs_tot[i] = TOT_RST;
        end
        for (int p = 0; p < NPIX; p++) begin
            if (zs_map[p]) begin
                if (k < NSLOT) begin
                    zs_tot[k[2:0]] = tot_r[p];
                end
                k = k + 5'h01;
            end
        end
    end

    for (genvar s = 0; s < NSTG; s++) begin : g_stg
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                stg_busy_r[s] <= 1'b0;
                stg_map_r[s]  <= '0;
                stg_cnt_r[s]  <= CNT_RST;
                stg_tmr_r[s]  <= 4'h0;
            end else if (start && stg_free[1:0] == s) begin
                stg_busy_r[s] <= 1'b1;
                stg_map_r[s]  <= disc;
                stg_cnt_r[s]  <= CNT_RST;
                stg_tmr_r[s]  <= tmr_free[3:0];
            end else if (stg_busy_r[s]) begin
                if (zs_fire && zs_pick[1:0] == s) begin
                    stg_busy_r[s] <= 1'b0;
                end else if (stg_cnt_r[s] != CNT_MAX) begin
                    stg_cnt_r[s] <= stg_cnt_r[s] + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // latency timers with hit map and shared width buffer
    for (genvar t = 0; t < NTMR; t++) begin : g_tmr
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                tmr_busy_r[t] <= 1'b0;
                tmr_trig_r[t] <= 1'b0;
                tmr_age_r[t]  <= AGE_RST;
                tmr_map_r[t]  <= '0;
                tmr_tid_r[t]  <= '0;
                for (int i = 0; i < NSLOT; i++) begin
                    tmr_tot_r[t][i] <= TOT_RST;
                end
            end else begin
                if (start && tmr_free[3:0] == t) begin
                    tmr_busy_r[t] <= 1'b1;
                    tmr_trig_r[t] <= 1'b0;
                    tmr_age_r[t]  <= AGE_RST;
                end else if (tmr_busy_r[t] && !tmr_trig_r[t]) begin
                    tmr_age_r[t] <= tmr_age_r[t] + 1'b1;
                    if (tmr_age_r[t] == latency) begin
                        if (trigger) begin
                            tmr_trig_r[t] <= 1'b1;
                            tmr_tid_r[t]  <= trigger_id;
                        end else begin
                            tmr_busy_r[t] <= 1'b0;
                            tmr_map_r[t]  <= '0;
                        end
                    end
                end else if (pkt_push && rd_pick[3:0] == t) begin
                    tmr_busy_r[t] <= 1'b0;
                    tmr_trig_r[t] <= 1'b0;
                    tmr_map_r[t]  <= '0;
                end
                // a timer already freed keeps its cleared map
                if (zs_fire && zs_tmr == t && tmr_busy_r[t]) begin
                    tmr_map_r[t] <= zs_map;
                    for (int i = 0; i < NSLOT; i++) begin
                        tmr_tot_r[t][i] <= zs_tot[i];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // adapter: rebuild a 16-code packet from map and slots
    always_comb begin
        logic [4:0]      k;
        logic [TOTW-1:0] code;
        k       = 5'h00;
        code    = TOT_RST;
        rd_pick = first_clear(~tmr_trig_r);
        pkt_map = tmr_map_r[rd_pick[3:0]];
        for (int i = 0; i < NSLOT; i++) begin
            pkt_tot[i] = tmr_tot_r[rd_pick[3:0]][i];
        end
        pkt_data = '0;
        pkt_data[PKTW-1 -: TIDW] = tmr_tid_r[rd_pick[3:0]];
        for (int p = 0; p < NPIX; p++) begin
            code = TOT_RST;
            if (pkt_map[p]) begin
                if (k >= NSLOT) begin
                    code = TOT_LOST;
                end else if (pkt_tot[k[2:0]] >= TOT_SAT_MIN) begin
                    code = TOT_SAT;
                end else begin
                    code = pkt_tot[k[2:0]];
                end
                k = k + 5'h01;
            end
            pkt_data[p*TOTW +: TOTW] = code;
        end
        pkt_push = rd_pick[4] & fifo_in_ready;
    end

    ssr_fifo #(
        .WIDTH (PKTW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (rd_pick[4]),
        .in_data   (pkt_data),
        .in_ready  (fifo_in_ready),
        .out_ready (out_ready),
        .out_valid (out_valid),
        .out_data  (out_data)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_one_start;
        start |=> $countones(tmr_busy_r & ~$past(tmr_busy_r)) == 1;
    endproperty
    a_one_start: assert property (p_one_start)
        else $error("more than one timer started");

    property p_lost;
        region_start && (&stg_busy_r) |=> hit_lost && !$past(start);
    endproperty
    a_lost: assert property (p_lost)
        else $error("fifth staged hit not reported lost");

    property p_free;
        tmr_busy_r[0] && !tmr_trig_r[0] && tmr_age_r[0] == latency
            && !trigger |=> !tmr_busy_r[0] && tmr_map_r[0] == '0;
    endproperty
    a_free: assert property (p_free)
        else $error("untriggered timer not freed");

    property p_keep;
        tmr_busy_r[0] && !tmr_trig_r[0] && tmr_age_r[0] == latency
            && trigger |=> tmr_trig_r[0] && tmr_tid_r[0] == $past(trigger_id);
    endproperty
    a_keep: assert property (p_keep)
        else $error("triggered timer not tagged");

    property p_release;
        pkt_push && rd_pick[3:0] == 4'h0 |=> !tmr_busy_r[0];
    endproperty
    a_release: assert property (p_release)
        else $error("timer not released after readout");

    property p_zs;
        zs_fire && zs_tmr == 4'h0 && tmr_busy_r[0]
            |=> tmr_map_r[0] == $past(zs_map);
    endproperty
    a_zs: assert property (p_zs)
        else $error("settled map not written");

    property p_sat;
        disc[0] && !hit_edge[0] && tot_r[0] == TOT_MAX
            ##1 disc[0] |-> tot_r[0] == TOT_MAX;
    endproperty
    a_sat: assert property (p_sat)
        else $error("width counter wrapped");

    property p_code_sat;
        pkt_push && pkt_map[0] && pkt_tot[0] >= TOT_SAT_MIN
            |-> pkt_data[3:0] == TOT_SAT;
    endproperty
    a_code_sat: assert property (p_code_sat)
        else $error("wide pulse not saturated");

    property p_code_lost;
        pkt_push && pkt_map[15] && $countones(pkt_map) > NSLOT
            |-> pkt_data[63:60] == TOT_LOST;
    endproperty
    a_code_lost: assert property (p_code_lost)
        else $error("overflow pixel not flagged");

    c_start: cover property (start ##[1:20] zs_fire);
    c_overflow: cover property (zs_fire && $countones(zs_map) > NSLOT);
    c_lost: cover property (hit_lost);
    c_push: cover property (pkt_push ##[1:40] out_valid && out_ready);
endmodule : ssr_region

/* ssr_region_tb.sv */
// self-checking bench for the shared-store region
`timescale 1ns/1ns

module ssr_region_tb;
    import ssr_pkg::*;

    localparam int L = 40;  // latency, above the settle interval
    localparam int S = 20;  // covers the longest width driven here

    typedef struct packed {
        logic [NPIX-1:0] mask;
        logic [4:0]      base;
        logic            trig;
        logic [TIDW-1:0] tid;
    } ssr_row_t;

    logic            ref_clk;
    logic            reset_n;
    logic [NPIX-1:0] disc;
    logic            trigger;
    logic [TIDW-1:0] trigger_id;
    logic [LATW-1:0] latency;
    logic [SETW-1:0] settle_time;
    logic            out_ready;
    logic            out_valid;
    logic [PKTW-1:0] out_data;
    logic            hit_lost;
    logic            stall;
    logic            slow;
    int              errors;
    int              checks;
    int              lost_cnt;

    // pixel p of a row stays high base+p cycles
    ssr_row_t rows [5] = '{
        '{16'h0001, 5'h14, 1'b1, 5'h03},
        '{16'hffff, 5'h04, 1'b1, 5'h1f},
        '{16'h0600, 5'h04, 1'b1, 5'h0a},
        '{16'h00f0, 5'h02, 1'b0, 5'h00},
        '{16'h01ff, 5'h01, 1'b1, 5'h11}};

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    ssr_region dut (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .disc        (disc),
        .latency     (latency),
        .settle_time (settle_time),
        .trigger     (trigger),
        .trigger_id  (trigger_id),
        .out_ready   (out_ready),
        .out_valid   (out_valid),
        .out_data    (out_data),
        .hit_lost    (hit_lost)
    );

    ssr_sink sink (
        .clk       (ref_clk),
        .reset_n   (reset_n),
        .stall     (stall),
        .slow      (slow),
        .out_valid (out_valid),
        .out_data  (out_data),
        .out_ready (out_ready)
    );

    ////////////////////////////////////////////////////////////////////
    // lost-hit pulses are counted, one per dropped region hit
    always @(posedge ref_clk) begin
        if (hit_lost === 1'b1)
            lost_cnt++;
    end

    task automatic check_pkt(string name, logic [PKTW-1:0] exp,
                             logic [PKTW-1:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_pkt

    task automatic check_val(string name, logic [31:0] exp,
                             logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_val

    task automatic summarize;
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // inputs move only on the falling edge
    task automatic step(logic [NPIX-1:0] d, logic t, logic [TIDW-1:0] id);
        @(negedge ref_clk);
        disc = d;
        trigger = t;
        trigger_id = id;
    endtask : step

    // expected packet: ascending pixels take the eight width slots
    function automatic logic [PKTW-1:0] exp_pkt(logic [NPIX-1:0] m,
                                                int base,
                                                logic [TIDW-1:0] tid);
        int n;
        int w;
        exp_pkt = '0;
        exp_pkt[PKTW-1 -: TIDW] = tid;
        n = 0;
        for (int p = 0; p < NPIX; p++) begin
            w = base + p;
            if (m[p]) begin
                exp_pkt[4*p +: 4] = n >= NSLOT ? TOT_LOST :
                                    w >= 14 ? TOT_SAT : TOTW'(w);
                n++;
            end
        end
    endfunction : exp_pkt

    function automatic logic [NPIX-1:0] level(logic [NPIX-1:0] m,
                                              int base, int c);
        for (int p = 0; p < NPIX; p++)
            level[p] = m[p] && c < base + p;
    endfunction : level

    // trigger lands on the edge where the timer reaches the latency
    task automatic drive_row(ssr_row_t r);
        int lat;
        lat = int'(latency);
        for (int c = 0; c <= lat + 1; c++)
            step(level(r.mask, r.base, c), r.trig && c == lat + 1, r.tid);
        step(NPIX'(0), 1'b0, TIDW'(0));
    endtask : drive_row

    task automatic run_row(ssr_row_t r);
        int              n;
        logic [PKTW-1:0] e;
        n = sink.rx_q.size();
        e = exp_pkt(r.mask, r.base, r.tid);
        drive_row(r);
        for (int i = 0; i < 20 && sink.rx_q.size() == n; i++)
            @(negedge ref_clk);
        check_val("packets", n + r.trig, sink.rx_q.size());
        if (r.trig)
            check_pkt("pkt", e, sink.rx_q[n]);
    endtask : run_row

    ////////////////////////////////////////////////////////////////////
    // watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    initial begin
        {disc, trigger, trigger_id, stall, slow} = '0;
        {errors, checks, lost_cnt} = '0;
        latency = LATW'(L);
        settle_time = SETW'(S);
        reset_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        check_val("reset valid", 0, out_valid);
        reset_n = 1'b1;
        foreach (rows[i])
            run_row(rows[i]);
        // second hit while the first settles forms its own map
        for (int c = 0; c <= L + 3; c++)
            step({14'h0, c >= 2 && c <= 4, c == 0},
                 c == L + 1 || c == L + 3, c == L + 1 ? 5'h05 : 5'h06);
        repeat (10) @(negedge ref_clk);
        check_pkt("map a", exp_pkt(16'h0001, 1, 5'h05), sink.rx_q[4]);
        check_pkt("map b", exp_pkt(16'h0002, 2, 5'h06), sink.rx_q[5]);
        // five starts in one interval: the fifth is dropped
        for (int c = 0; c < 5; c++)
            step(NPIX'(1) << c, 1'b0, TIDW'(0));
        step(NPIX'(0), 1'b0, TIDW'(0));
        repeat (L + 10) @(negedge ref_clk);
        check_val("lost", 1, lost_cnt);
        check_val("no packet", 6, sink.rx_q.size());
        // a longer latency and settle interval, changed while all is idle
        latency = LATW'(L + 20);
        settle_time = SETW'(S + 10);
        run_row(rows[2]);
        latency = LATW'(L);
        settle_time = SETW'(S);
        // stall the sink so the fifo fills and a timer must wait
        sink.rx_q.delete();
        stall = 1'b1;
        for (int c = 0; c <= 102 + L + 1; c++)
            step(c % 6 == 0 && c < 108 ? NPIX'(1) << (c / 6 % 16) : '0,
                 c > L && (c - L - 1) % 6 == 0 && c - L - 1 < 108,
                 TIDW'((c - L - 1) / 6));
        step(NPIX'(0), 1'b0, TIDW'(0));
        repeat (4) @(negedge ref_clk);
        check_val("stalled", 0, sink.rx_q.size());
        check_val("held valid", 1, out_valid);
        check_pkt("held", exp_pkt(16'h0001, 1, 5'h00), out_data);
        stall = 1'b0;
        slow = 1'b1;
        for (int i = 0; i < 200 && sink.rx_q.size() < 18; i++)
            @(negedge ref_clk);
        check_val("drained", 18, sink.rx_q.size());
        for (int i = 0; i < 18; i++)
            check_pkt("queued", exp_pkt(NPIX'(1) << (i % 16), 1 - i % 16,
                      TIDW'(i)), sink.rx_q[i]);
        check_val("lost after", 1, lost_cnt);
        // reset in mid-run drops a packet that waits for the sink
        slow = 1'b0;
        stall = 1'b1;
        drive_row(rows[1]);
        repeat (5) @(negedge ref_clk);
        check_val("wait valid", 1, out_valid);
        reset_n = 1'b0;
        @(negedge ref_clk);
        check_val("reset valid", 0, out_valid);
        check_val("reset lost", 0, hit_lost);
        check_pkt("reset data", '0, out_data);
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        stall = 1'b0;
        repeat (60) @(negedge ref_clk);
        check_val("after reset", 18, sink.rx_q.size());
        summarize();
    end
endmodule : ssr_region_tb

/* ssr_sink.sv */
// packet sink standing in for the column readout and periphery side
`timescale 1ns/1ns

module ssr_sink (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     stall,
    input  wire logic                     slow,
    input  wire logic                     out_valid,
    input  wire logic [ssr_pkg::PKTW-1:0] out_data,
    output logic                          out_ready
);
    import ssr_pkg::*;

    logic [PKTW-1:0] rx_q[$];

    ////////////////////////////////////////////////////////////////////
    // ready is registered, so it only moves just after an edge;
    // slow mode halves the rate to stall the fifo part of the time
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            out_ready <= 1'b0;
        else
            out_ready <= !stall && !(slow && out_ready);
    end

    // a packet is taken on the edge where valid and ready meet
    always @(posedge clk) begin
        if (reset_n && out_valid && out_ready)
            rx_q.push_back(out_data);
    end
endmodule : ssr_sink
